// ===== verilog/wtu_consts.svh
// Register offsets, field positions and timing counts of the watchdog
`ifndef WTU_CONSTS_SVH
`define WTU_CONSTS_SVH

`define WTU_ADDR_W 8
`define WTU_ADDR_CAUSE 8'h54
`define WTU_ADDR_CTRL 8'h60

`define WTU_CAUSE_WATCHDOG_RESET_FLAG 3

`define WTU_CTRL_IFLAG 7
`define WTU_CTRL_IEN 6
`define WTU_CTRL_PS3 5
`define WTU_CTRL_UNLOCK 4
`define WTU_CTRL_REN 3

`define WTU_PS_RESET 4'h0
`define WTU_PS_MAX 4'h9
`define WTU_BASE_CYCLES 21'h00_0800
`define WTU_CNT_W 21

`define WTU_SYS_HZ 10000000
`define WTU_OSC_HZ 128000
`define WTU_OSC_DIV (`WTU_SYS_HZ / `WTU_OSC_HZ)
`define WTU_DIV_W 7

`define WTU_UNLOCK_CYCLES 3'h4

`endif

// ===== verilog/wtu_pkg.sv
// Types shared by the watchdog files
`default_nettype none
package wtu_pkg;
  typedef enum logic [3:0] {
    WTU_STOPPED = 4'b0001,
    WTU_IRQ = 4'b0010,
    WTU_RESET = 4'b0100,
    WTU_BOTH = 4'b1000
  } wtu_mode_t;
endpackage
`default_nettype wire

// ===== verilog/wtu_sync.sv
// Three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module wtu_sync #(
  parameter logic RESET_VALUE = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic asyncIn,
  output logic syncOut
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_syncOut;

  always_comb begin
    next_stage = {stage[1:0], asyncIn};
    next_syncOut = (stage[2] == stage[1]) ? stage[2] : syncOut;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage <= {3{RESET_VALUE}};
      syncOut <= RESET_VALUE;
    end else begin
      stage <= next_stage;
      syncOut <= next_syncOut;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/wtu_watchdog.sv
// Watchdog timer with timed unlock for clearing reset-enable and for prescaler changes
`timescale 1ns/1ps
`default_nettype none
`include "wtu_consts.svh"
module wtu_watchdog (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [`WTU_ADDR_W-1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  input wire logic restartCmd,
  input wire logic irqAck,
  input wire logic alwaysOnFuse_b,
  output logic irqReq,
  output logic sysResetReq,
  output wtu_pkg::wtu_mode_t mode
);
  import wtu_pkg::*;

  logic fuseProg_b;
  logic fuseProg;
  logic [`WTU_DIV_W-1:0] divCnt;
  logic [`WTU_DIV_W-1:0] next_divCnt;
  logic oscTick;
  logic next_oscTick;
  logic [`WTU_CNT_W-1:0] tickCnt;
  logic [`WTU_CNT_W-1:0] next_tickCnt;
  logic [`WTU_CNT_W-1:0] limit;
  logic [3:0] prescale;
  logic [3:0] next_prescale;
  logic resetEnable;
  logic next_resetEnable;
  logic irqEnable;
  logic next_irqEnable;
  logic irqFlag;
  logic next_irqFlag;
  logic resetFlag;
  logic next_resetFlag;
  logic [2:0] unlockCnt;
  logic [2:0] next_unlockCnt;
  logic next_sysResetReq;
  logic [7:0] next_rdData;
  logic effReset;
  logic effIrq;
  logic running;
  logic expire;
  logic ctrlWr;
  logic causeWr;
  logic windowOpen;
  logic openWr;
  logic [7:0] ctrlView;
  wtu_mode_t next_mode;

  wtu_sync #(
    .RESET_VALUE(1'b1)
  ) u_fuse_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .asyncIn(alwaysOnFuse_b),
    .syncOut(fuseProg_b)
  );

  assign fuseProg = ~fuseProg_b;

  // Oscillator rate made from the system clock; it never stops, sleep or not
  always_comb begin
    next_oscTick = 1'b0;
    next_divCnt = divCnt + `WTU_DIV_W'(1);
    if (divCnt == `WTU_DIV_W'(`WTU_OSC_DIV - 1)) begin
      next_divCnt = '0;
      next_oscTick = 1'b1;
    end
  end

  // Reserved prescaler codes behave as the longest period
  always_comb begin
    if (prescale > `WTU_PS_MAX) begin
      limit = `WTU_BASE_CYCLES << `WTU_PS_MAX;
    end else begin
      limit = `WTU_BASE_CYCLES << prescale;
    end
  end

  assign effReset = resetEnable | resetFlag | fuseProg;
  assign effIrq = irqEnable & ~fuseProg;
  assign running = effReset | effIrq;
  assign expire = running & oscTick & (tickCnt == limit - `WTU_CNT_W'(1));
  assign ctrlWr = wrStb & (addr == `WTU_ADDR_CTRL);
  assign causeWr = wrStb & (addr == `WTU_ADDR_CAUSE);
  assign windowOpen = (unlockCnt != 3'h0);
  assign openWr = ctrlWr & wrData[`WTU_CTRL_UNLOCK] & wrData[`WTU_CTRL_REN];
  assign irqReq = irqFlag & effIrq;
  assign ctrlView = {irqFlag, effIrq, prescale[3], windowOpen, effReset, prescale[2:0]};

  always_comb begin
    if (!effReset && !effIrq) begin
      next_mode = WTU_STOPPED;
    end else if (effReset && effIrq) begin
      next_mode = WTU_BOTH;
    end else if (effReset) begin
      next_mode = WTU_RESET;
    end else begin
      next_mode = WTU_IRQ;
    end
  end

  always_comb begin
    next_tickCnt = tickCnt;
    next_prescale = prescale;
    next_resetEnable = resetEnable;
    next_irqEnable = irqEnable;
    next_irqFlag = irqFlag;
    next_resetFlag = resetFlag;
    next_unlockCnt = windowOpen ? unlockCnt - 3'h1 : 3'h0;
    next_sysResetReq = 1'b0;
    next_rdData = 8'h00;

    if (rdStb) begin
      if (addr == `WTU_ADDR_CTRL) begin
        next_rdData = ctrlView;
      end else if (addr == `WTU_ADDR_CAUSE) begin
        next_rdData = 8'(resetFlag) << `WTU_CAUSE_WATCHDOG_RESET_FLAG;
      end
    end

    // Software side first so that hardware events below win the same cycle
    if (causeWr && !wrData[`WTU_CAUSE_WATCHDOG_RESET_FLAG]) begin
      next_resetFlag = 1'b0;
    end
    if (ctrlWr) begin
      next_irqEnable = wrData[`WTU_CTRL_IEN];
      if (wrData[`WTU_CTRL_IFLAG]) begin
        next_irqFlag = 1'b0;
      end
      if (openWr) begin
        next_resetEnable = 1'b1;
        next_unlockCnt = `WTU_UNLOCK_CYCLES;
      end else if (windowOpen && !wrData[`WTU_CTRL_UNLOCK]) begin
        next_resetEnable = wrData[`WTU_CTRL_REN];
        next_prescale = {wrData[`WTU_CTRL_PS3], wrData[2:0]};
        next_unlockCnt = 3'h0;
      end else begin
        next_resetEnable = resetEnable | wrData[`WTU_CTRL_REN];
      end
    end

    if (irqAck && irqFlag) begin
      next_irqFlag = 1'b0;
      if (effReset) begin
        next_irqEnable = 1'b0;
      end
    end

    if (restartCmd) begin
      next_tickCnt = '0;
    end else if (!running) begin
      next_tickCnt = '0;
    end else if (oscTick) begin
      next_tickCnt = expire ? '0 : tickCnt + `WTU_CNT_W'(1);
    end

    if (expire && !restartCmd) begin
      if (effReset && (!effIrq || irqFlag)) begin
        // Acts as the system reset of this block; the flag keeps it armed
        next_sysResetReq = 1'b1;
        next_resetFlag = 1'b1;
        next_irqEnable = 1'b0;
        next_irqFlag = 1'b0;
        next_prescale = `WTU_PS_RESET;
        next_unlockCnt = 3'h0;
      end else begin
        next_irqFlag = 1'b1;
      end
    end

    if (next_resetFlag) begin
      next_resetEnable = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      divCnt <= '0;
      oscTick <= 1'b0;
      tickCnt <= '0;
      prescale <= `WTU_PS_RESET;
      resetEnable <= 1'b0;
      irqEnable <= 1'b0;
      irqFlag <= 1'b0;
      resetFlag <= 1'b0;
      unlockCnt <= 3'h0;
      sysResetReq <= 1'b0;
      rdData <= 8'h00;
      mode <= WTU_STOPPED;
    end else begin
      divCnt <= next_divCnt;
      oscTick <= next_oscTick;
      tickCnt <= next_tickCnt;
      prescale <= next_prescale;
      resetEnable <= next_resetEnable;
      irqEnable <= next_irqEnable;
      irqFlag <= next_irqFlag;
      resetFlag <= next_resetFlag;
      unlockCnt <= next_unlockCnt;
      sysResetReq <= next_sysResetReq;
      rdData <= next_rdData;
      mode <= next_mode;
    end
  end
endmodule
`default_nettype wire

// ===== dv/wtu_monitor.sv
// Port-level checks for the watchdog
`timescale 1ns/1ps
`default_nettype none
`include "wtu_consts.svh"
module wtu_monitor (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [`WTU_ADDR_W-1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [7:0] rdData,
  input wire logic restartCmd,
  input wire logic irqAck,
  input wire logic alwaysOnFuse_b,
  input wire logic irqReq,
  input wire logic sysResetReq,
  input wire wtu_pkg::wtu_mode_t mode
);
  import wtu_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_RST_PULSE: assert property (sysResetReq |=> !sysResetReq)
    else $error("reset request longer than one cycle");
  AST_RST_MODE: assert property (sysResetReq |-> (mode == WTU_RESET || mode == WTU_BOTH))
    else $error("reset request outside a reset mode");
  AST_AFTER_RST: assert property (sysResetReq |=> mode == WTU_RESET)
    else $error("watchdog not left in reset mode");
  AST_FUSE: assert property (!alwaysOnFuse_b [*6] |=> mode == WTU_RESET)
    else $error("fuse did not force reset mode");
  AST_IRQ_MODE: assert property ($rose(irqReq) |-> ##1 (mode == WTU_IRQ || mode == WTU_BOTH || !irqReq))
    else $error("interrupt request without interrupt mode");
  AST_UNLOCK_SELF: assert property (wrStb && addr == `WTU_ADDR_CTRL && wrData[4] && wrData[3]
    ##1 !wrStb [*6] ##0 (rdStb && addr == `WTU_ADDR_CTRL) |=> !rdData[4])
    else $error("unlock bit did not clear itself");
  AST_RESTART: assert property (restartCmd |=> !sysResetReq ##1 !sysResetReq)
    else $error("reset request right after restart");
  AST_IRQ_ACK: assert property (irqAck && irqReq |=> !irqReq)
    else $error("interrupt request stayed after acknowledge");
endmodule
`default_nettype wire

// ===== dv/wtu_watchdog_tb_top.sv
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "wtu_consts.svh"
module wtu_watchdog_tb_top;
  import wtu_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [`WTU_ADDR_W-1:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic restartCmd = 1'b0;
  logic irqAck = 1'b0;
  logic alwaysOnFuse_b = 1'b1;
  logic [7:0] rdData;
  logic irqReq;
  logic sysResetReq;
  wtu_mode_t mode;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  int waited;
  wtu_watchdog dut (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .restartCmd(restartCmd), .irqAck(irqAck),
    .alwaysOnFuse_b(alwaysOnFuse_b), .irqReq(irqReq), .sysResetReq(sysResetReq), .mode(mode));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Strobe left high so back-to-back writes need no gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    rdStb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rdStb <= 1'b1;
    wrStb <= 1'b0;
    @(posedge clk_sys);
    rdStb <= 1'b0;
    #1 chk(rdData, exp);
  endtask
  task automatic idle(input int n);
    wrStb <= 1'b0;
    rdStb <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 200000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(`WTU_ADDR_CTRL, 8'h00);
    wr(`WTU_ADDR_CAUSE, 8'h00);
    rd(`WTU_ADDR_CAUSE, 8'h00);
    wr(8'h77, 8'hFF);
    rd(8'h77, 8'h00);
    wr(`WTU_ADDR_CTRL, 8'h0D);
    rd(`WTU_ADDR_CTRL, 8'h08);
    wr(`WTU_ADDR_CTRL, 8'h00);
    rd(`WTU_ADDR_CTRL, 8'h08);
    restartCmd <= 1'b1;
    wr(`WTU_ADDR_CTRL, 8'h18);
    restartCmd <= 1'b0;
    rd(`WTU_ADDR_CTRL, 8'h18);
    wr(`WTU_ADDR_CTRL, 8'h0D);
    rd(`WTU_ADDR_CTRL, 8'h0D);
    wr(`WTU_ADDR_CTRL, 8'h18);
    idle(5);
    rd(`WTU_ADDR_CTRL, 8'h0D);
    wr(`WTU_ADDR_CTRL, 8'h00);
    rd(`WTU_ADDR_CTRL, 8'h0D);
    wr(`WTU_ADDR_CTRL, 8'h18);
    wr(`WTU_ADDR_CTRL, 8'h00);
    rd(`WTU_ADDR_CTRL, 8'h00);
    chk({4'h0, mode}, {4'h0, WTU_STOPPED});
    wr(`WTU_ADDR_CTRL, 8'h40);
    restartCmd <= 1'b1;
    wrStb <= 1'b0;
    @(posedge clk_sys);
    restartCmd <= 1'b0;
    waited = 0;
    // Tick phase is free-running, so allow one tick of slack
    while (irqReq !== 1'b1 && waited < 170000) begin
      @(posedge clk_sys);
      #1 waited++;
    end
    chk({7'h00, (waited >= 159660 && waited <= 159750)}, 8'h01);
    rd(`WTU_ADDR_CTRL, 8'hC0);
    irqAck <= 1'b1;
    @(posedge clk_sys);
    irqAck <= 1'b0;
    #1 chk({7'h00, irqReq}, 8'h00);
    rd(`WTU_ADDR_CTRL, 8'h40);
    alwaysOnFuse_b <= 1'b0;
    idle(8);
    chk({4'h0, mode}, {4'h0, WTU_RESET});
    wr(`WTU_ADDR_CTRL, 8'h40);
    rd(`WTU_ADDR_CTRL, 8'h08);
    wrap_up();
  end
endmodule
bind wtu_watchdog wtu_monitor mon (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
  .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .restartCmd(restartCmd),
  .irqAck(irqAck), .alwaysOnFuse_b(alwaysOnFuse_b), .irqReq(irqReq),
  .sysResetReq(sysResetReq), .mode(mode));
`default_nettype wire
